// file: char_pattern_generator.sv
// Character pattern generator: position mapping, pattern rom, user pattern ram
`timescale 1ns/100ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Contract
// - After one right shift line one shows 27H at position one and line two 67H, the rest the preceding address.
// - The pattern rom gives a glyph for every 8-bit code, up to 192 small and 32 tall ones.
// - A 64-byte user pattern ram holds eight small or four tall glyphs, spare bytes being plain storage.
// - Codes 00H to 07H render the matching user glyph instead of a rom glyph.
// - Only the low five bits of a row byte reach the dots.
// - With increment set, each row write advances the pattern address by one.
// - Code bits 0 to 2 form pattern address bits 3 to 5 for small glyphs; for tall ones code bits 1 and 2 form bits 4 and 5.
// - Address bits 0 to 2 pick a small row (bits 0 to 3 a tall one), and the eighth small or eleventh tall row is ORed with the cursor.
// - Data bits 0 to 4 are the dot columns, bit 4 leftmost.
// - Data bits 5 to 7 are stored and read back as ordinary memory.
// - User ram is selected when code bits 4 to 7 are zero, code bit 3 being ignored.
// - A one lights a dot, a zero leaves it dark.
// - Each data write or read steps the counter up when direction is one, down when zero.
module char_pattern_generator
   import char_pattern_pkg::*;
#(
   parameter int SHIFT_SPAN = LINE_SPAN,
   parameter logic [4:0] ROM_INIT [0:255][0:ROM_ROWS-1] = '{default: '{default: 5'h00}}
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire host_acc_t host_acc,
   input wire disp_req_t disp_req,
   output logic [7:0] host_rdata,
   output logic host_rvalid,
   output logic [5:0] ram_address_counter,
   output disp_out_t disp_out
);

   //////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   generate
      // Span must reach every position and stay inside the shift field
      if (SHIFT_SPAN < (1 << $bits(disp_req.pos)) || SHIFT_SPAN > (1 << $bits(disp_req.shift)))
      begin : g_bad_span
         $error("SHIFT_SPAN must cover all positions and fit the shift field");
      end
      // Wrap span must not run into the next line
      if (int'(LINE2_BASE - LINE1_BASE) < SHIFT_SPAN)
      begin : g_bad_lines
         $error("SHIFT_SPAN overlaps the second line of text");
      end
      // Counter must reach exactly every ram byte
      if (USER_RAM_BYTES != (1 << $bits(ram_address_counter)))
      begin : g_bad_ram
         $error("USER_RAM_BYTES must equal the reach of the address counter");
      end
      if (DOT_COLS > $bits(host_rdata))
      begin : g_bad_cols
         $error("DOT_COLS must fit inside one pattern byte");
      end
      if (int'(CURSOR_ROW_TALL) >= ROM_ROWS)
      begin : g_bad_rows
         $error("ROM_ROWS must reach the tall cursor row");
      end
      if (ROM_SMALL_TYPES + ROM_TALL_TYPES > $size(ROM_INIT, 1))
      begin : g_bad_rom
         $error("ROM_INIT holds fewer codes than the pattern rom needs");
      end
   endgenerate

   typedef struct packed {
      logic [USER_RAM_BYTES-1:0][7:0] user_pattern_ram;
      logic [5:0] ac;
      logic [7:0] rdata;
      logic rvalid;
      disp_out_t dout;
   } state_t;

   state_t state_ff;
   state_t nxt_state;

   //////////////////////////////////////////////////////////////////////////
   // Helpers

   // Text address of a screen position under a right shift
   function automatic logic [6:0] pos_to_addr(input logic line2, input logic [2:0] pos, input logic [5:0] shift);
      logic [7:0] ofs;
      logic [7:0] span;
      span = 8'(SHIFT_SPAN);
      ofs = 8'(pos) + span - 8'(shift);
      if (ofs >= span)
      begin
         ofs = ofs - span;
      end
      pos_to_addr = (line2 ? LINE2_BASE : LINE1_BASE) + ofs[6:0];
   endfunction

   // Counter step after a data access, wrapping inside the ram
   function automatic logic [5:0] step_ac(input logic [5:0] ac, input logic incr);
      step_ac = incr ? ac + AC_STEP : ac - AC_STEP;
   endfunction

   // User ram address from code and row
   function automatic logic [5:0] user_addr(input logic [7:0] code, input logic [3:0] row, input logic tall);
      if (tall)
      begin
         user_addr = {code[2:1], row[ROW_TALL_MSB:0]};
      end
      else
      begin
         user_addr = {code[2:0], row[ROW_SMALL_MSB:0]};
      end
   endfunction

   // Bottom row of a glyph, the one that carries the cursor
   function automatic logic [3:0] last_row(input logic tall);
      last_row = tall ? CURSOR_ROW_TALL : CURSOR_ROW_SMALL;
   endfunction

   // User glyphs sit where the high code bits are clear; bit 3 plays no part
   function automatic logic is_user_code(input logic [7:0] code);
      is_user_code = (code[7:CODE_HI_LSB] == USER_SEL_HIGH);
   endfunction

   // Dot columns of a stored row byte; the bits above them never light
   function automatic logic [4:0] byte_dots(input logic [7:0] row_byte);
      byte_dots = row_byte[DOT_COLS-1:0];
   endfunction

   // Pattern rom row, taken from a parameter rather than fixed bitmaps
   function automatic logic [4:0] rom_dots(input logic [7:0] code, input logic [3:0] row);
      rom_dots = ROM_INIT[code][row];
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      logic [7:0] row_byte;
      logic [4:0] dots;
      logic sel_user;
      logic cur_row;
      logic [3:0] row_lim;
      row_byte = 8'h00;
      dots = 5'h00;
      sel_user = 1'b0;
      cur_row = 1'b0;
      row_lim = 4'h0;
      nxt_state = state_ff;
      nxt_state.rvalid = 1'b0;

      // Host side; an address set overrides a data access in the same cycle
      if (host_acc.set_addr)
      begin
         nxt_state.ac = host_acc.addr;
      end
      else if (host_acc.wr)
      begin
         nxt_state.user_pattern_ram[state_ff.ac] = host_acc.wdata;
         nxt_state.ac = step_ac(state_ff.ac, host_acc.incr);
      end
      else if (host_acc.rd)
      begin
         nxt_state.rdata = state_ff.user_pattern_ram[state_ff.ac];
         nxt_state.rvalid = 1'b1;
         nxt_state.ac = step_ac(state_ff.ac, host_acc.incr);
      end

      // Display side
      nxt_state.dout.valid = disp_req.valid;
      if (disp_req.valid)
      begin
         sel_user = is_user_code(disp_req.code);
         row_lim = last_row(disp_req.tall);
         cur_row = (disp_req.row == row_lim);
         if (disp_req.row > row_lim)
         begin
            dots = 5'h00;
         end
         else if (sel_user)
         begin
            row_byte = state_ff.user_pattern_ram[user_addr(disp_req.code, disp_req.row, disp_req.tall)];
            dots = byte_dots(row_byte);
         end
         else
         begin
            dots = rom_dots(disp_req.code, disp_req.row);
         end
         if (cur_row && disp_req.cursor)
         begin
            dots = dots | {DOT_COLS{1'b1}};
         end
         nxt_state.dout.dots = dots;
         nxt_state.dout.from_user = sel_user;
         nxt_state.dout.text_addr = pos_to_addr(disp_req.line2, disp_req.pos, disp_req.shift);
      end

      if (!reset_n)
      begin
         nxt_state = '0;
         nxt_state.rdata = RDATA_RESET;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Registers and outputs

   always_ff @(posedge clk)
   begin
      state_ff <= nxt_state;
   end

   assign host_rdata = state_ff.rdata;
   assign host_rvalid = state_ff.rvalid;
   assign ram_address_counter = state_ff.ac;
   assign disp_out = state_ff.dout;

endmodule
`default_nettype wire

// file: char_pattern_pkg.sv
// Shared constants and carrier types for the character pattern generator
package char_pattern_pkg;
   localparam logic [6:0] LINE1_BASE = 7'h00;
   localparam logic [6:0] LINE2_BASE = 7'h40;
   localparam int LINE_SPAN = 40;
   localparam int USER_RAM_BYTES = 64;
   localparam int DOT_COLS = 5;
   localparam int ROM_ROWS = 16;
   localparam int ROM_SMALL_TYPES = 192;
   localparam int ROM_TALL_TYPES = 32;
   localparam logic [3:0] CURSOR_ROW_SMALL = 4'h7;
   localparam logic [3:0] CURSOR_ROW_TALL = 4'ha;
   localparam logic [3:0] USER_SEL_HIGH = 4'h0;
   localparam int CODE_HI_LSB = 4;
   localparam int ROW_SMALL_MSB = 2;
   localparam int ROW_TALL_MSB = 3;
   localparam logic [5:0] AC_STEP = 6'h01;
   localparam logic [7:0] RDATA_RESET = 8'h00;

   // Host access to the user pattern ram through the address counter
   typedef struct packed {
      logic set_addr;
      logic [5:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
      logic incr;
   } host_acc_t;

   // Display scan request for one dot row of one position
   typedef struct packed {
      logic valid;
      logic line2;
      logic [2:0] pos;
      logic [5:0] shift;
      logic [7:0] code;
      logic [3:0] row;
      logic tall;
      logic cursor;
   } disp_req_t;

   // Display scan answer
   typedef struct packed {
      logic valid;
      logic [6:0] text_addr;
      logic [4:0] dots;
      logic from_user;
   } disp_out_t;
endpackage

// file: char_pattern_generator_properties.sv
// Port checker for the character pattern generator
`timescale 1ns/100ps
`default_nettype none
module char_pattern_generator_properties
   import char_pattern_pkg::*;
#(
   parameter int SHIFT_SPAN = LINE_SPAN
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire host_acc_t host_acc,
   input wire disp_req_t disp_req,
   input wire logic [7:0] host_rdata,
   input wire logic host_rvalid,
   input wire logic [5:0] ram_address_counter,
   input wire disp_out_t disp_out
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   sequence acc_s;
      (host_acc.wr || host_acc.rd) && !host_acc.set_addr;
   endsequence
   sequence rd_s;
      host_acc.rd && !host_acc.wr && !host_acc.set_addr;
   endsequence
   load_addr_a: assert property (host_acc.set_addr |=> ram_address_counter == $past(host_acc.addr))
      else $error("bad load");
   step_up_a: assert property (acc_s ##0 host_acc.incr |=> ram_address_counter == $past(ram_address_counter) + 6'h01)
      else $error("bad step up");
   step_down_a: assert property (acc_s ##0 !host_acc.incr |=> ram_address_counter == $past(ram_address_counter) - 6'h01)
      else $error("bad step down");
   property shift_map_p;
      disp_req.valid |=> disp_out.text_addr == 7'({$past(disp_req.line2), 6'h00}
         + ($past(disp_req.pos) + SHIFT_SPAN - $past(disp_req.shift)) % SHIFT_SPAN);
   endproperty
   property cursor_row_p;
      disp_req.valid && !disp_req.tall && disp_req.row == 4'h7 && disp_req.cursor |=> disp_out.dots == 5'h1f;
   endproperty
   read_pulse_a: assert property (rd_s |=> host_rvalid)
      else $error("bad read pulse");
   read_quiet_a: assert property (!(host_acc.rd && !host_acc.wr && !host_acc.set_addr) |=> !host_rvalid)
      else $error("stray read pulse");
   scan_answer_a: assert property (disp_out.valid == ($past(disp_req.valid) && $past(reset_n)))
      else $error("bad scan answer");
   shift_map_a: assert property (shift_map_p)
      else $error("bad text address");
   user_sel_a: assert property (disp_req.valid |=> disp_out.from_user == ($past(disp_req.code[7:4]) == 4'h0))
      else $error("bad ram select");
   cursor_row_a: assert property (cursor_row_p)
      else $error("bad cursor row");
endmodule
bind char_pattern_generator char_pattern_generator_properties #(.SHIFT_SPAN(SHIFT_SPAN)) chk_i (.clk(clk),
   .reset_n(reset_n), .host_acc(host_acc), .disp_req(disp_req), .host_rdata(host_rdata),
   .host_rvalid(host_rvalid), .ram_address_counter(ram_address_counter), .disp_out(disp_out));
`default_nettype wire

// file: host_glyph_model.sv
// Host model that programs user glyphs
`timescale 1ns/100ps
`default_nettype none
module host_glyph_model
   import char_pattern_pkg::*;
(
   input wire logic clk,
   output var host_acc_t acc
);
   initial acc = '0;
   // Request held for exactly one edge
   task automatic op(input logic s, w, r, i, input logic [7:0] d);
      acc <= '{s, d[5:0], w, r, d, i};
      @(posedge clk);
   endtask
   task automatic glyph(input logic [2:0] c);
      op(1'h1, 1'h0, 1'h0, 1'h1, {2'h0, c, 3'h0});
      for (int r = 0; r < 7; r++)
         op(1'h0, 1'h1, 1'h0, 1'h1, 8'he0 + 8'(r * 5));
      op(1'h0, 1'h1, 1'h0, 1'h1, 8'h00);
      op(1'h0, 1'h0, 1'h0, 1'h1, 8'h00);
   endtask
endmodule
`default_nettype wire

// file: char_pattern_generator_bench.sv
// Self-checking bench for the character pattern generator
`timescale 1ns/100ps
`default_nettype none
module char_pattern_generator_bench;
   import char_pattern_pkg::*;
   logic clk;
   logic reset_n;
   host_acc_t host_acc;
   disp_req_t disp_req;
   logic [7:0] host_rdata;
   logic host_rvalid;
   logic [5:0] ram_address_counter;
   disp_out_t disp_out;
   int fails = 0;
   int n_compared = 0;
   localparam logic [4:0] ROM_FILL = 5'h15;
   char_pattern_generator #(.ROM_INIT('{default: '{default: ROM_FILL}})) uut (.clk(clk), .reset_n(reset_n),
      .host_acc(host_acc), .disp_req(disp_req),
      .host_rdata(host_rdata), .host_rvalid(host_rvalid), .ram_address_counter(ram_address_counter),
      .disp_out(disp_out));
   host_glyph_model host (.clk(clk), .acc(host_acc));
   task automatic chk(input logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      if (fails == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic scan(input logic l, logic [2:0] p, logic [5:0] s, logic [7:0] c, logic [3:0] r, logic cur, logic t);
      @(posedge clk);
      disp_req <= '{1'h1, l, p, s, c, r, t, cur};
      @(posedge clk);
      disp_req.valid <= 1'h0;
      #1;
      chk(disp_out.valid, 8'h01);
   endtask
   task automatic glyph_test;
      host.glyph(3'h1);
      #1;
      chk(ram_address_counter, 8'h10);
      for (int r = 0; r < 9; r++)
      begin
         scan(1'h0, 3'h0, 6'h00, 8'h09, 4'(r), 1'h0, 1'h0);
         chk(disp_out.dots, r < 7 ? 8'(r * 5) : 8'h00);
         chk(disp_out.from_user, 8'h01);
      end
      scan(1'h0, 3'h0, 6'h00, 8'h09, 4'h7, 1'h1, 1'h0);
      chk(disp_out.dots, 8'h1f);
      scan(1'h0, 3'h0, 6'h00, 8'h01, 4'h9, 1'h0, 1'h1);
      chk(disp_out.dots, 8'h05);
      scan(1'h0, 3'h0, 6'h00, 8'h01, 4'ha, 1'h1, 1'h1);
      chk(disp_out.dots, 8'h1f);
      scan(1'h0, 3'h0, 6'h00, 8'h01, 4'hb, 1'h1, 1'h1);
      chk(disp_out.dots, 8'h00);
   endtask
   task automatic shift_test;
      for (int l = 0; l < 2; l++)
         for (int p = 0; p < 8; p++)
         begin
            scan(1'(l), 3'(p), 6'h01, 8'h41, 4'h0, 1'h0, 1'h0);
            chk(disp_out.text_addr, 8'(l * 64 + (p + LINE_SPAN - 1) % LINE_SPAN));
            chk(disp_out.dots, 8'(ROM_FILL));
            chk(disp_out.from_user, 8'h00);
         end
   endtask
   task automatic readback_test;
      @(posedge clk);
      host.op(1'h1, 1'h0, 1'h0, 1'h0, 8'h0a);
      host.op(1'h0, 1'h0, 1'h1, 1'h0, 8'h00);
      fork
         host.op(1'h0, 1'h0, 1'h0, 1'h0, 8'h00);
         begin
            #1;
            chk(host_rvalid, 8'h01);
         end
      join
      #1;
      chk(host_rvalid, 8'h00);
      chk(host_rdata, 8'hea);
      chk(ram_address_counter, 8'h09);
      @(posedge clk);
      host.op(1'h1, 1'h0, 1'h0, 1'h1, 8'h3f);
      host.op(1'h0, 1'h1, 1'h0, 1'h1, 8'ha5);
      host.op(1'h0, 1'h0, 1'h0, 1'h1, 8'h00);
      #1;
      chk(ram_address_counter, 8'h00);
      @(posedge clk);
      host.op(1'h1, 1'h0, 1'h0, 1'h1, 8'h3f);
      host.op(1'h0, 1'h0, 1'h1, 1'h1, 8'h00);
      host.op(1'h0, 1'h0, 1'h0, 1'h1, 8'h00);
      #1;
      chk(host_rdata, 8'ha5);
   endtask
   initial
   begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      reset_n = 1'h0;
      disp_req = '0;
      repeat (12) @(posedge clk);
      reset_n <= 1'h1;
      @(posedge clk);
      glyph_test;
      shift_test;
      readback_test;
      conclude;
   end
   // About 100 cycles needed, 4000 allowed
   initial
   begin
      #100000;
      fails++;
      conclude;
   end
endmodule
`default_nettype wire
